// ==== core/ssmp_defs.svh ====
`ifndef SSMP_DEFS_SVH
`define SSMP_DEFS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SSMP_OFF_CTRL_HIGH 8'h00
`define SSMP_OFF_CTRL_LOW 8'h04
`define SSMP_OFF_MODE 8'h08
`define SSMP_OFF_ENABLE 8'h0C
`define SSMP_OFF_STATUS 8'h10
`define SSMP_OFF_CTRL_TWO 8'h14
`define SSMP_OFF_TX_DATA 8'h18
`define SSMP_OFF_RX_DATA 8'h1C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SSMP_CH_MASTER 7
`define SSMP_CH_BIDIR 6
`define SSMP_CH_LEVEL 4
`define SSMP_CH_GUARD 3
`define SSMP_CH_CSFUNC_HI 1
`define SSMP_CH_CSFUNC_LO 0
`define SSMP_CL_CLRMODE 7
`define SSMP_CL_PROTO 6
`define SSMP_CL_SRST 5
`define SSMP_CL_WLEN_HI 1
`define SSMP_CL_WLEN_LO 0
`define SSMP_MD_MSB 7
`define SSMP_MD_CPOL 6
`define SSMP_MD_CPHA 5
`define SSMP_MD_DIV_HI 2
`define SSMP_MD_DIV_LO 0
`define SSMP_EN_TX 7
`define SSMP_EN_RX 6
`define SSMP_EN_DONE_IE 3
`define SSMP_EN_EMPTY_IE 2
`define SSMP_EN_RX_IE 1
`define SSMP_EN_CONF_IE 0
`define SSMP_ST_OVERRUN 6
`define SSMP_ST_DONE 3
`define SSMP_ST_EMPTY 2
`define SSMP_ST_FULL 1
`define SSMP_ST_CONFLICT 0
`define SSMP_C2_DONE_TIMING 4
`define SSMP_C2_CS_TIMING 3
`define SSMP_C2_DO_TIMING 2

// ----------------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------------
`define SSMP_RST_CTRL_HIGH 8'h00
`define SSMP_RST_CTRL_LOW 8'h00
`define SSMP_RST_MODE 8'h00
`define SSMP_RST_ENABLE 8'h00
`define SSMP_RST_CTRL_TWO 8'h00
`define SSMP_RST_DATA 8'h00
`define SSMP_CSFUNC_AUTO 2'h3
`define SSMP_WORD_BITS 8
`define SSMP_LAST_HALF 4'hF

`endif

// ==== core/ssmp_pkg.sv ====
package ssmp_pkg;

   typedef enum logic [1:0] {
      SSMP_IDLE,
      SSMP_LEAD,
      SSMP_SHIFT,
      SSMP_TRAIL
   } ssmp_state_type;

   typedef struct packed {
      logic sckOut;
      logic sckOe;
      logic csOut;
      logic csOe;
      logic sdoOut;
      logic sdoOe;
   } ssmp_pins_type;

   typedef struct packed {
      logic txDone;
      logic txEmpty;
      logic rxFull;
      logic overrun;
      logic conflict;
   } ssmp_irq_type;

endpackage

// ==== core/ssmp_sync_serial_master_port.sv ====
// Chosen here: the register offsets and register access over APB.
`include "ssmp_defs.svh"

module ssmp_sync_serial_master_port
   import ssmp_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic mclk, // system clock
   input wire logic rstn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   output ssmp_pins_type pins, // serial pin drives and enables
   input wire logic serialDataInPin, // data in pin
   input wire logic serialDataOutPinIn, // data out pin level, used in bidirectional mode
   output ssmp_irq_type irq // gated interrupt requests
);

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   logic masterSelect, bidirSelect, dataOutLevel;
   logic [1:0] chipSelectFunction;
   logic flagClearMode, protocolModeSelect, softReset;
   logic [1:0] wordLengthSelect;
   logic msbFirstSelect, clockIdlePolarity, clockPhaseSelect;
   logic [2:0] clockDividerSelect;
   logic transmitEnable, rxEnable;
   logic txDoneIrqEnable, txEmptyIrqEnable, rxIrqEnable, conflictIrqEnable;
   logic doneFlagTiming, selectAssertTiming, dataOutTiming;
   logic overrunFlag, txDoneFlag, txBufferEmpty, rxBufferFull, conflictFlag;
   logic [7:0] txData, rxData;

   // ----------------------------------------------------------------------
   // engine state
   // ----------------------------------------------------------------------
   ssmp_state_type state;
   logic [7:0] divCnt;
   logic [3:0] halfIdx;
   logic [7:0] txShift, rxShift;
   logic sckLevel, sdoReg, csActive;
   logic halfTick, wordEnd, active, canStart, moreWork, startNext, abort;
   logic changeEdge, sampleEdge, sampleBit;
   logic setDone, setEmpty, setFull, setOverrun, setConflict;
   logic [7:0] divLast, loadWord;

   // ----------------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------------
   logic setupPhase, wrAccess, rdAccess, mapped;
   logic [7:0] readMux;

   assign pready = 1'b1;
   assign setupPhase = psel & ~penable;
   assign wrAccess = psel & penable & pwrite;
   assign rdAccess = psel & penable & ~pwrite;

   always_comb begin
      mapped = 1'b1;
      readMux = 8'h00;
      unique case (paddr)
         `SSMP_OFF_CTRL_HIGH: readMux = {masterSelect, bidirSelect, 1'b0, dataOutLevel,
                                         1'b1, 1'b0, chipSelectFunction};
         `SSMP_OFF_CTRL_LOW: readMux = {flagClearMode, protocolModeSelect, softReset,
                                        3'h0, wordLengthSelect};
         `SSMP_OFF_MODE: readMux = {msbFirstSelect, clockIdlePolarity, clockPhaseSelect,
                                    2'h0, clockDividerSelect};
         `SSMP_OFF_ENABLE: readMux = {transmitEnable, rxEnable, 2'h0, txDoneIrqEnable,
                                      txEmptyIrqEnable, rxIrqEnable, conflictIrqEnable};
         `SSMP_OFF_STATUS: readMux = {1'b0, overrunFlag, 2'h0, txDoneFlag, txBufferEmpty,
                                      rxBufferFull, conflictFlag};
         `SSMP_OFF_CTRL_TWO: readMux = {3'h0, doneFlagTiming, selectAssertTiming,
                                        dataOutTiming, 2'h0};
         `SSMP_OFF_TX_DATA: readMux = txData;
         `SSMP_OFF_RX_DATA: readMux = rxData;
         default: mapped = 1'b0;
      endcase
   end

   // read data and error are captured in the setup cycle so both come from flops
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setupPhase) begin
         prdata <= {24'h000000, readMux};
         pslverr <= ~mapped;
      end
   end

   function automatic logic hit(input logic [ADDR_W-1:0] off);
      hit = (paddr == off);
   endfunction

   // ----------------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         {masterSelect, bidirSelect} <= 2'h0;
         dataOutLevel <= 1'b0;
         chipSelectFunction <= 2'h0;
      end else if (wrAccess && hit(`SSMP_OFF_CTRL_HIGH)) begin
         masterSelect <= pwdata[`SSMP_CH_MASTER];
         bidirSelect <= pwdata[`SSMP_CH_BIDIR];
         if (!pwdata[`SSMP_CH_GUARD]) begin
            dataOutLevel <= pwdata[`SSMP_CH_LEVEL];
         end
         chipSelectFunction <= pwdata[`SSMP_CH_CSFUNC_HI:`SSMP_CH_CSFUNC_LO];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         {flagClearMode, protocolModeSelect, softReset} <= 3'h0;
         wordLengthSelect <= 2'h0;
         {msbFirstSelect, clockIdlePolarity, clockPhaseSelect} <= 3'h0;
         clockDividerSelect <= 3'h0;
         {transmitEnable, rxEnable} <= 2'h0;
         {txDoneIrqEnable, txEmptyIrqEnable, rxIrqEnable, conflictIrqEnable} <= 4'h0;
         {doneFlagTiming, selectAssertTiming, dataOutTiming} <= 3'h0;
      end else if (wrAccess) begin
         if (hit(`SSMP_OFF_CTRL_LOW)) begin
            flagClearMode <= pwdata[`SSMP_CL_CLRMODE];
            protocolModeSelect <= pwdata[`SSMP_CL_PROTO];
            softReset <= pwdata[`SSMP_CL_SRST];
            wordLengthSelect <= pwdata[`SSMP_CL_WLEN_HI:`SSMP_CL_WLEN_LO];
         end
         if (hit(`SSMP_OFF_MODE)) begin
            msbFirstSelect <= pwdata[`SSMP_MD_MSB];
            clockIdlePolarity <= pwdata[`SSMP_MD_CPOL];
            clockPhaseSelect <= pwdata[`SSMP_MD_CPHA];
            clockDividerSelect <= pwdata[`SSMP_MD_DIV_HI:`SSMP_MD_DIV_LO];
         end
         if (hit(`SSMP_OFF_ENABLE)) begin
            transmitEnable <= pwdata[`SSMP_EN_TX];
            rxEnable <= pwdata[`SSMP_EN_RX];
            txDoneIrqEnable <= pwdata[`SSMP_EN_DONE_IE];
            txEmptyIrqEnable <= pwdata[`SSMP_EN_EMPTY_IE];
            rxIrqEnable <= pwdata[`SSMP_EN_RX_IE];
            conflictIrqEnable <= pwdata[`SSMP_EN_CONF_IE];
         end
         if (hit(`SSMP_OFF_CTRL_TWO)) begin
            doneFlagTiming <= pwdata[`SSMP_C2_DONE_TIMING];
            selectAssertTiming <= pwdata[`SSMP_C2_CS_TIMING];
            dataOutTiming <= pwdata[`SSMP_C2_DO_TIMING];
         end
      end
   end

   // only the 8-bit word length exists; the word length field is stored and
   // read back but never selects the unused data registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         txData <= `SSMP_RST_DATA;
      end else if (wrAccess && hit(`SSMP_OFF_TX_DATA)) begin
         txData <= pwdata[7:0];
      end
   end

   // ----------------------------------------------------------------------
   // status flags: a hardware set beats a software clear in the same cycle
   // ----------------------------------------------------------------------
   logic wrStatus, wrTx, rdRx, accessClear;
   assign wrStatus = wrAccess && hit(`SSMP_OFF_STATUS);
   assign wrTx = wrAccess && hit(`SSMP_OFF_TX_DATA);
   assign rdRx = rdAccess && hit(`SSMP_OFF_RX_DATA);
   assign accessClear = ~flagClearMode;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         {overrunFlag, txDoneFlag, rxBufferFull, conflictFlag} <= 4'h0;
         txBufferEmpty <= 1'b1;
      end else if (softReset) begin
         {overrunFlag, txDoneFlag, rxBufferFull, conflictFlag} <= 4'h0;
         txBufferEmpty <= 1'b1;
      end else begin
         if (setEmpty) begin
            txBufferEmpty <= 1'b1;
         end else if (wrTx) begin
            txBufferEmpty <= 1'b0;
         end
         if (setDone) begin
            txDoneFlag <= 1'b1;
         end else if ((wrTx && accessClear) || (wrStatus && !pwdata[`SSMP_ST_DONE])) begin
            txDoneFlag <= 1'b0;
         end
         if (setFull) begin
            rxBufferFull <= 1'b1;
         end else if ((rdRx && accessClear) || (wrStatus && !pwdata[`SSMP_ST_FULL])) begin
            rxBufferFull <= 1'b0;
         end
         if (setOverrun) begin
            overrunFlag <= 1'b1;
         end else if (wrStatus && !pwdata[`SSMP_ST_OVERRUN]) begin
            overrunFlag <= 1'b0;
         end
         if (setConflict) begin
            conflictFlag <= 1'b1;
         end else if (wrStatus && !pwdata[`SSMP_ST_CONFLICT]) begin
            conflictFlag <= 1'b0;
         end
      end
   end

   always_comb begin
      irq.txDone = txDoneFlag & txDoneIrqEnable;
      irq.txEmpty = txBufferEmpty & txEmptyIrqEnable;
      irq.rxFull = rxBufferFull & rxIrqEnable;
      irq.overrun = overrunFlag & rxIrqEnable;
      irq.conflict = conflictFlag & conflictIrqEnable;
   end

   // ----------------------------------------------------------------------
   // transfer engine
   // ----------------------------------------------------------------------
   // half period is 2**divider cycles, so divider 011 gives a clock of mclk/16
   assign divLast = 8'((8'h01 << clockDividerSelect) - 8'h01);
   assign halfTick = (divCnt == divLast);
   assign active = (state != SSMP_IDLE);
   assign wordEnd = (state == SSMP_SHIFT) && halfTick && (halfIdx == `SSMP_LAST_HALF);
   // receive-only transfers clock out the idle level while rx data is free
   assign canStart = masterSelect && ((transmitEnable && !txBufferEmpty) ||
                     (!transmitEnable && rxEnable && !rxBufferFull));
   assign moreWork = canStart;
   assign startNext = wordEnd && moreWork;
   assign abort = active && !(masterSelect && (transmitEnable || rxEnable));
   // odd edges (even half index) are first edges of a clock cycle
   assign changeEdge = (state == SSMP_SHIFT) && halfTick &&
                       (halfIdx[0] == clockPhaseSelect);
   assign sampleEdge = (state == SSMP_SHIFT) && halfTick &&
                       (halfIdx[0] != clockPhaseSelect);
   assign sampleBit = bidirSelect ? serialDataOutPinIn : serialDataInPin;
   assign loadWord = transmitEnable ? txData : {8{dataOutLevel}};
   assign setEmpty = transmitEnable && ((state == SSMP_IDLE && canStart) || startNext);
   assign setFull = wordEnd && rxEnable && !rxBufferFull;
   assign setOverrun = wordEnd && rxEnable && rxBufferFull;
   assign setConflict = abort;
   // with done timing clear the flag rises as the last bit starts, else after it
   assign setDone = transmitEnable && txBufferEmpty && !moreWork && (doneFlagTiming ?
                    wordEnd : ((state == SSMP_SHIFT) && halfTick &&
                    (halfIdx == 4'hD)));

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state <= SSMP_IDLE;
         divCnt <= 8'h00;
         halfIdx <= 4'h0;
      end else if (softReset || abort) begin
         state <= SSMP_IDLE;
         divCnt <= 8'h00;
         halfIdx <= 4'h0;
      end else begin
         divCnt <= (halfTick || state == SSMP_IDLE) ? 8'h00 : 8'(divCnt + 8'h01);
         unique case (state)
            SSMP_IDLE: begin
               if (canStart) begin
                  state <= SSMP_LEAD;
                  // cs timing set: a full clock cycle of lead instead of a half
                  halfIdx <= selectAssertTiming ? 4'hE : 4'hF;
               end
            end
            SSMP_LEAD: begin
               if (halfTick) begin
                  halfIdx <= 4'(halfIdx + 4'h1);
                  if (halfIdx == `SSMP_LAST_HALF) begin
                     state <= SSMP_SHIFT;
                  end
               end
            end
            SSMP_SHIFT: begin
               if (halfTick) begin
                  halfIdx <= 4'(halfIdx + 4'h1);
                  if (wordEnd && !moreWork) begin
                     state <= SSMP_TRAIL;
                  end
               end
            end
            SSMP_TRAIL: begin
               if (halfTick) begin
                  state <= SSMP_IDLE;
               end
            end
         endcase
      end
   end

   function automatic logic [7:0] shiftOn(input logic [7:0] w, input logic b);
      shiftOn = msbFirstSelect ? {w[6:0], b} : {b, w[7:1]};
   endfunction

   function automatic logic headBit(input logic [7:0] w);
      headBit = msbFirstSelect ? w[7] : w[0];
   endfunction

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         txShift <= 8'h00;
         sdoReg <= 1'b0;
      end else if (softReset || state == SSMP_IDLE && !canStart) begin
         sdoReg <= dataOutLevel;
      end else if ((state == SSMP_IDLE && canStart) || startNext) begin
         // phase 1 needs the first bit on the pin before the first edge
         txShift <= clockPhaseSelect ? shiftOn(loadWord, 1'b0) : loadWord;
         if (clockPhaseSelect) begin
            sdoReg <= headBit(loadWord);
         end
      end else if (changeEdge && !(clockPhaseSelect && halfIdx == `SSMP_LAST_HALF)) begin
         sdoReg <= headBit(txShift);
         txShift <= shiftOn(txShift, 1'b0);
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rxShift <= 8'h00;
      end else if (sampleEdge) begin
         rxShift <= shiftOn(rxShift, sampleBit);
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rxData <= `SSMP_RST_DATA;
      end else if (setFull) begin
         rxData <= shiftOn(rxShift, sampleBit);
      end
   end

   // ----------------------------------------------------------------------
   // pin drivers
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sckLevel <= 1'b1;
         csActive <= 1'b0;
      end else begin
         if (state == SSMP_SHIFT && halfTick) begin
            sckLevel <= ~sckLevel;
         end else if (state != SSMP_SHIFT) begin
            sckLevel <= ~clockIdlePolarity;
         end
         csActive <= (state == SSMP_IDLE) ? (canStart && !softReset && !abort) :
                     !(state == SSMP_TRAIL && halfTick);
      end
   end

   always_comb begin
      pins.sckOut = sckLevel;
      pins.sckOe = masterSelect;
      pins.csOut = ~csActive;
      pins.csOe = masterSelect && (chipSelectFunction == `SSMP_CSFUNC_AUTO);
      pins.sdoOut = sdoReg;
      // data timing set: drive the pin whenever transmit is enabled, else only
      // while a word is on the link; bidirectional mode does not release it
      pins.sdoOe = transmitEnable && (dataOutTiming || active);
   end

endmodule

// ==== bench/ssmp_checker.sv ====
`include "ssmp_defs.svh"

module ssmp_checker
   import ssmp_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic mclk, // clock
   input wire logic rstn, // reset
   input wire logic psel, // select
   input wire logic penable, // enable
   input wire logic pwrite, // direction
   input wire logic [ADDR_W-1:0] paddr, // address
   input wire logic [31:0] pwdata, // write data
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // ready
   input wire logic pslverr, // error
   input wire ssmp_pins_type pins, // pins
   input wire logic serialDataInPin, // data in
   input wire logic serialDataOutPinIn, // data out level
   input wire ssmp_irq_type irq // requests
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   // ------------------------------------------------------------
   // shadow config, taken from apb writes so pin checks know the mode
   // ------------------------------------------------------------
   logic wr;
   logic [7:0] off;
   logic [7:0] modeReg;
   logic [7:0] enReg;
   logic [7:0] twoReg;
   assign wr = psel && penable && pwrite;
   assign off = 8'(paddr);
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         modeReg <= 8'h00;
         enReg <= 8'h00;
         twoReg <= 8'h00;
      end else if (wr) begin
         if (off == `SSMP_OFF_MODE) modeReg <= pwdata[7:0];
         if (off == `SSMP_OFF_ENABLE) enReg <= pwdata[7:0];
         if (off == `SSMP_OFF_CTRL_TWO) twoReg <= pwdata[7:0];
      end
   end
   a_master_clock_oe: assert property (
      wr && off == 8'h00 |=> pins.sckOe == $past(pwdata[7])) else $error("clock enable wrong");
   a_auto_select_oe: assert property (
      wr && off == 8'h00 |=> pins.csOe == ($past(pwdata[7]) && $past(pwdata[1:0]) == 2'h3))
      else $error("select enable wrong");
   a_idle_clock_high: assert property (
      pins.csOe && pins.csOut && !modeReg[6] && !$past(modeReg[6]) |-> pins.sckOut)
      else $error("clock not idle high");
   a_edges_in_frame: assert property (
      $changed(pins.sckOut) && modeReg == $past(modeReg, 2) |-> !pins.csOut || !$past(pins.csOut))
      else $error("clock edge outside select");
   a_sample_stable: assert property (
      $changed(pins.sckOut) && pins.sckOut != modeReg[6] && !pins.csOut && !modeReg[5]
      |-> $stable(pins.sdoOut)) else $error("data moved on sample edge");
   a_half_period: assert property (
      $changed(pins.sckOut) && pins.sckOut == modeReg[6] && !pins.csOut && modeReg[2:0] == 3'h3
      |=> $stable(pins.sckOut) [*7] ##1 $changed(pins.sckOut)) else $error("half period wrong");
   a_tx_write_clears: assert property (
      wr && off == 8'h18 && enReg[2] |=> !irq.txEmpty) else $error("empty not cleared");
   a_irq_gating: assert property (
      (irq & ~{enReg[3], enReg[2], enReg[1], enReg[1], enReg[0]}) == 5'h00)
      else $error("request not gated");
   a_done_after_last: assert property (
      $rose(irq.txDone) && twoReg[4] |-> pins.sckOut != modeReg[6]) else $error("done too early");
   a_soft_reset_idle: assert property (
      wr && off == 8'h04 && pwdata[5] |=> ##1
      (pins.csOut && !irq.txDone && !irq.rxFull && !irq.overrun))
      else $error("soft reset ignored");
   a_tx_gate: assert property (
      !enReg[7] |-> !pins.sdoOe) else $error("data driven while disabled");
   a_select_lead: assert property (
      $fell(pins.csOut) && twoReg[3] && modeReg[2:0] == 3'h3
      |-> ##16 (pins.sckOut != modeReg[6]) ##8 (pins.sckOut == modeReg[6]))
      else $error("select lead wrong");
endmodule

bind ssmp_sync_serial_master_port ssmp_checker #(.ADDR_W(ADDR_W)) u_chk (.mclk(mclk),
   .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
   .serialDataInPin(serialDataInPin), .serialDataOutPinIn(serialDataOutPinIn), .irq(irq));

// ==== bench/ssmp_slave_model.sv ====
module ssmp_slave_model (
   input wire logic mclk, // clock
   input wire logic sck, // serial clock
   input wire logic csN, // select, active low
   input wire logic sdo, // master data
   input wire logic cpol, // active clock level
   input wire logic [7:0] reply, // word to return
   output logic sdi, // data to master
   output logic [7:0] got // last word taken
);
   timeunit 1ns;
   timeprecision 1ns;
   logic lastSck = 1'b1;
   logic [7:0] sh = 8'h00;
   logic [2:0] cnt = 3'h0;
   initial sdi = 1'b0;
   initial got = 8'h00;
   always @(posedge mclk) begin
      lastSck <= sck;
      if (csN) begin
         // deselected: keep moving so a stale level is never mistaken for data
         sdi <= ~sdi;
         sh <= reply;
         cnt <= 3'h0;
      end else if (sck != lastSck && sck == cpol) begin
         sdi <= sh[7];
         sh <= {sh[6:0], 1'b0};
      end else if (sck != lastSck) begin
         got <= {got[6:0], sdo};
         cnt <= cnt + 3'h1;
         if (cnt == 3'h7) sh <= reply;
      end
   end
endmodule

// ==== bench/tb_sync_serial_master_port.sv ====
module tb_sync_serial_master_port
   import ssmp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, sdi, sdoLine, sckLine, csLine;
   logic [7:0] reply = 8'hA5;
   logic [7:0] got;
   ssmp_pins_type pins;
   ssmp_irq_type irq;
   int mismatches = 0;
   int checkCount = 0;
   logic [7:0] regAddr [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
   logic [7:0] regRst [8] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};

   initial forever #10 mclk = ~mclk;
   // lines are pulled up, so a released pin reads high
   assign sckLine = pins.sckOe ? pins.sckOut : 1'b1;
   assign csLine = pins.csOe ? pins.csOut : 1'b1;
   assign sdoLine = pins.sdoOe ? pins.sdoOut : 1'b1;

   ssmp_sync_serial_master_port #(.ADDR_W(8)) u_dut (.mclk(mclk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pins(pins), .serialDataInPin(sdi),
      .serialDataOutPinIn(sdoLine), .irq(irq));
   ssmp_slave_model u_slave (.mclk(mclk), .sck(sckLine), .csN(csLine), .sdo(sdoLine),
      .cpol(1'b0), .reply(reply), .sdi(sdi), .got(got));

   // ------------------------------------------------------------
   // bus tasks
   // ------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checkCount, mismatches);
      if (mismatches == 0 && checkCount > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checkCount++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // take data at the completing edge, before anything is released
      rd = {prdata[31:1], prdata[0]};
      check({31'h0, pslverr}, {31'h0, a > 8'h1C}, "error response");
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         mismatches++;
         report_and_stop();
      end
   endtask

   task automatic waitFlag(input int bitNo);
      int n;
      n = 0;
      do begin
         apb(1'b0, 8'h10, 8'h00);
         n++;
      end while (rd[bitNo] !== 1'b1 && n < 300);
      if (n >= 300) begin
         mismatches++;
         report_and_stop();
      end
   endtask

   initial begin
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      foreach (regAddr[i]) begin
         apb(1'b0, regAddr[i], 8'h00);
         check(rd, {24'h000000, regRst[i]}, "reset value");
      end
      apb(1'b0, 8'h20, 8'h00);
      check(rd, 32'h00000000, "unmapped read");
      $display("test reset done");
      apb(1'b1, 8'h00, 8'h18);
      apb(1'b0, 8'h00, 8'h00);
      check(rd, 32'h00000008, "guarded level");
      apb(1'b1, 8'h00, 8'h93);
      apb(1'b0, 8'h00, 8'h00);
      check(rd, 32'h0000009B, "level written");
      check({29'h0, pins.sckOe, pins.csOe, pins.sckOut}, 32'h00000007, "master pins");
      $display("test control done");
      apb(1'b1, 8'h08, 8'h83);
      apb(1'b1, 8'h14, 8'h10);
      apb(1'b1, 8'h18, 8'h5A);
      apb(1'b0, 8'h18, 8'h00);
      check(rd, 32'h0000005A, "tx readback");
      apb(1'b0, 8'h10, 8'h00);
      check(rd, 32'h00000000, "empty cleared");
      check({31'h0, pins.csOut}, 32'h00000001, "no transfer while off");
      apb(1'b1, 8'h0C, 8'hCE);
      waitFlag(2);
      apb(1'b1, 8'h18, 8'hC3);
      reply <= 8'h3C;
      waitFlag(1);
      check({24'h0, got}, 32'h0000005A, "slave got first");
      apb(1'b0, 8'h1C, 8'h00);
      check(rd, 32'h000000A5, "first reply");
      waitFlag(1);
      apb(1'b0, 8'h1C, 8'h00);
      check(rd, 32'h0000003C, "second reply");
      waitFlag(3);
      check({24'h0, got}, 32'h000000C3, "slave got second");
      check(rd, 32'h0000000C, "status after pair");
      check({27'h0, irq}, 32'h00000018, "requests after pair");
      $display("test transfer done");
      apb(1'b1, 8'h18, 8'h11);
      waitFlag(3);
      reply <= 8'h77;
      apb(1'b1, 8'h18, 8'h22);
      waitFlag(3);
      check(rd, 32'h0000004E, "overrun status");
      check({27'h0, irq}, 32'h0000001E, "overrun requests");
      apb(1'b0, 8'h1C, 8'h00);
      check(rd, 32'h0000003C, "rx kept on overrun");
      apb(1'b0, 8'h10, 8'h00);
      check(rd, 32'h0000004C, "full cleared by read");
      $display("test overrun done");
      apb(1'b1, 8'h04, 8'h20);
      apb(1'b0, 8'h10, 8'h00);
      check(rd, 32'h00000004, "flags after soft reset");
      apb(1'b0, 8'h00, 8'h00);
      check(rd, 32'h0000009B, "config kept");
      apb(1'b1, 8'h04, 8'h00);
      $display("test soft reset done");
      apb(1'b1, 8'h14, 8'h1C);
      apb(1'b0, 8'h14, 8'h00);
      check(rd, 32'h0000001C, "ctrl two readback");
      check({31'h0, pins.sdoOe}, 32'h00000001, "data driven while idle");
      apb(1'b1, 8'h18, 8'h96);
      waitFlag(3);
      check({24'h0, got}, 32'h00000096, "slave got late select");
      $display("test timing done");
      report_and_stop();
   end
endmodule
